// ---- pkg/qtf_pkg.sv ----
package qtf_pkg;
    // register byte offsets on the host register port
    localparam logic [11:0] TX_NEXT_FRAME_SPACE_OFS = 12'h19E;
    localparam logic [11:0] MULTICAST_HASH_WORD0_OFS = 12'h1A0;
    localparam logic [11:0] MULTICAST_HASH_WORD1_OFS = 12'h1A2;
    localparam logic [11:0] MULTICAST_HASH_WORD2_OFS = 12'h1A4;
    localparam logic [11:0] MULTICAST_HASH_WORD3_OFS = 12'h1A6;
    localparam logic [11:0] RX_FLOW_LOW_MARK_OFS = 12'h1B0;
    localparam logic [11:0] RX_FLOW_HIGH_MARK_OFS = 12'h1B2;

    // reset values
    localparam logic [15:0] TX_NEXT_FRAME_SPACE_RST = 16'h0000;
    localparam logic [15:0] HASH_WORD_RST = 16'h0000;
    localparam logic [11:0] LOW_MARK_RST = 12'h600;
    localparam logic [11:0] HIGH_MARK_RST = 12'h400;

    // widths
    localparam int MARK_W = 12;
    localparam int HASH_IDX_W = 6;
    localparam int DA_BYTES = 6;

    // control field positions
    localparam int TX_MEM_MONITOR_BIT = 1;
    localparam int RX_RECEIVE_ALL_BIT = 4;
    localparam int RX_MCAST_FILTER_BIT = 8;
    localparam int IRQ_TX_SPACE_BIT = 6;

    // receive filtering mode that enables the hash table
    localparam logic [2:0] FILTER_MODE_HASH_PERFECT = 3'h5;

    // ethernet crc, non-reflected form, data fed lsb first
    localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
endpackage : qtf_pkg

// ---- src/qtf_da_crc.sv ----
`timescale 1ns/100ps
`default_nettype none
// running crc over destination address bytes, one byte per strobe
module qtf_da_crc (
    input wire logic clk,
    input wire logic resetn,
    input wire logic byte_valid,
    input wire logic byte_first,
    input wire logic [7:0] byte_data,
    output logic [31:0] crc
);
    logic [31:0] crc_r;
    logic [31:0] crc_nxt;
    logic [31:0] crc_seed;

    // one byte of crc, bits taken lsb first as they leave the wire
    function automatic logic [31:0] qtf_crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] x;
        logic fb;
        x = c;
        for (int i = 0; i < 8; i++) begin
            fb = x[31] ^ d[i];
            x = {x[30:0], 1'b0} ^ (fb ? qtf_pkg::CRC_POLY : 32'h00000000);
        end
        return x;
    endfunction : qtf_crc_byte

    // the first byte restarts from the preset so no frame leaks into the next
    assign crc_seed = byte_first ? qtf_pkg::CRC_INIT : crc_r;
    assign crc_nxt = qtf_crc_byte(crc_seed, byte_data);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            crc_r <= qtf_pkg::CRC_INIT;
        end else if (byte_valid) begin
            crc_r <= crc_nxt;
        end
    end

    assign crc = crc_r;
endmodule : qtf_da_crc
`default_nettype wire

// ---- src/qtf_hash_lookup.sv ----
`timescale 1ns/100ps
`default_nettype none
// registered multicast decision from the 64-bit table
module qtf_hash_lookup (
    input wire logic clk,
    input wire logic resetn,
    input wire logic go,
    input wire logic is_mcast,
    input wire logic [63:0] table_bits,
    input wire logic [5:0] index,
    input wire logic hash_mode,
    input wire logic pass_all_mcast,
    output logic done,
    output logic accept
);
    logic done_r;
    logic accept_r;
    logic [15:0] word_sel;
    logic bit_sel;
    logic accept_nxt;

    // top two index bits pick the word, low four the bit in it
    assign word_sel = table_bits[index[5:4] * 16 +: 16];
    assign bit_sel = word_sel[index[3:0]];

    // only multicast frames in hash mode are judged; the rest pass untouched
    assign accept_nxt = !is_mcast || !hash_mode || pass_all_mcast || bit_sel;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            done_r <= 1'b0;
            accept_r <= 1'b0;
        end else begin
            done_r <= go;
            if (go) begin
                accept_r <= accept_nxt;
            end
        end
    end

    assign done = done_r;
    assign accept = accept_r;
endmodule : qtf_hash_lookup
`default_nettype wire

// ---- src/qtf_space_hash_filter.sv ----
`timescale 1ns/100ps
`default_nettype none
module qtf_space_hash_filter (
    input wire logic clk,
    input wire logic resetn,
    // host register port, 16-bit data, byte addressed
    input wire logic [11:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [1:0] reg_be,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // control bits held elsewhere in the queue manager
    input wire logic [15:0] tx_queue_control,
    input wire logic [15:0] rx_control_one,
    input wire logic [2:0] rx_filter_mode,
    // transmit queue space monitor
    input wire logic [15:0] tx_queue_free_dw,
    output logic tx_space_irq_set,
    // destination address bytes of each received frame
    input wire logic [7:0] rx_da_byte,
    input wire logic rx_da_valid,
    input wire logic rx_da_first,
    output logic rx_filter_done,
    output logic rx_filter_accept,
    output logic [5:0] rx_hash_index,
    // receive queue flow control
    input wire logic [11:0] rx_queue_free_dw,
    output logic rx_flow_ctrl
);
    // merge a 16-bit write under byte enables
    // lanes whose enable is low keep their old contents
    function automatic logic [15:0] qtf_merge(input logic [15:0] old, input logic [15:0] wd,
                                              input logic [1:0] be);
        return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : qtf_merge

    // registers
    logic [15:0] tx_next_frame_space_r;
    logic [15:0] multicast_hash_word_r [4];
    logic [11:0] rx_flow_low_mark_r;
    logic [11:0] rx_flow_high_mark_r;
    logic [15:0] reg_rdata_r;
    logic reg_rvalid_r;

    // address decode; the bus carries byte addresses of even words
    logic wr_next_space;
    logic wr_low_mark;
    logic wr_high_mark;
    logic [3:0] wr_hash;
    logic [15:0] rd_mux;
    logic [15:0] low_mark_wide;
    logic [15:0] high_mark_wide;

    // one hit per mapped word, shared by the write strobes and the read mux;
    // the address is compared in full, so the odd byte of a word is unmapped
    logic hit_next_space;
    logic hit_low_mark;
    logic hit_high_mark;
    logic [3:0] hit_hash;

    assign hit_next_space = (reg_addr == qtf_pkg::TX_NEXT_FRAME_SPACE_OFS);
    assign hit_low_mark = (reg_addr == qtf_pkg::RX_FLOW_LOW_MARK_OFS);
    assign hit_high_mark = (reg_addr == qtf_pkg::RX_FLOW_HIGH_MARK_OFS);
    assign hit_hash[0] = (reg_addr == qtf_pkg::MULTICAST_HASH_WORD0_OFS);
    assign hit_hash[1] = (reg_addr == qtf_pkg::MULTICAST_HASH_WORD1_OFS);
    assign hit_hash[2] = (reg_addr == qtf_pkg::MULTICAST_HASH_WORD2_OFS);
    assign hit_hash[3] = (reg_addr == qtf_pkg::MULTICAST_HASH_WORD3_OFS);

    // write strobes, one per mapped word
    assign wr_next_space = reg_wr && hit_next_space;
    assign wr_low_mark = reg_wr && hit_low_mark;
    assign wr_high_mark = reg_wr && hit_high_mark;
    assign wr_hash[0] = reg_wr && hit_hash[0];
    assign wr_hash[1] = reg_wr && hit_hash[1];
    assign wr_hash[2] = reg_wr && hit_hash[2];
    assign wr_hash[3] = reg_wr && hit_hash[3];

    // reserved upper bits of the water marks read as zero
    assign low_mark_wide = {4'h0, rx_flow_low_mark_r};
    assign high_mark_wide = {4'h0, rx_flow_high_mark_r};

    // read selection; unmapped addresses read zero
    assign rd_mux =
        hit_next_space ? tx_next_frame_space_r :
        hit_hash[0] ? multicast_hash_word_r[0] :
        hit_hash[1] ? multicast_hash_word_r[1] :
        hit_hash[2] ? multicast_hash_word_r[2] :
        hit_hash[3] ? multicast_hash_word_r[3] :
        hit_low_mark ? low_mark_wide :
        hit_high_mark ? high_mark_wide :
        16'h0000;

    // transmit space request, written by the host ahead of each frame
    // no range check: a request larger than the queue simply never fires
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tx_next_frame_space_r <= qtf_pkg::TX_NEXT_FRAME_SPACE_RST;
        end else if (wr_next_space) begin
            tx_next_frame_space_r <= qtf_merge(tx_next_frame_space_r, reg_wdata, reg_be);
        end
    end

    // hash table words
    // the table may change between frames; a decision uses the bits at its go edge
    generate
        for (genvar w = 0; w < 4; w++) begin : g_hash_word
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    multicast_hash_word_r[w] <= qtf_pkg::HASH_WORD_RST;
                end else if (wr_hash[w]) begin
                    multicast_hash_word_r[w] <= qtf_merge(multicast_hash_word_r[w], reg_wdata,
                                                          reg_be);
                end
            end
        end
    endgenerate

    // water marks, only the low twelve bits are stored
    logic [15:0] low_mark_merged;
    logic [15:0] high_mark_merged;
    assign low_mark_merged = qtf_merge(low_mark_wide, reg_wdata, reg_be);
    assign high_mark_merged = qtf_merge(high_mark_wide, reg_wdata, reg_be);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rx_flow_low_mark_r <= qtf_pkg::LOW_MARK_RST;
            rx_flow_high_mark_r <= qtf_pkg::HIGH_MARK_RST;
        end else begin
            if (wr_low_mark) begin
                rx_flow_low_mark_r <= low_mark_merged[11:0];
            end
            if (wr_high_mark) begin
                rx_flow_high_mark_r <= high_mark_merged[11:0];
            end
        end
    end

    // read data is registered, valid one cycle after the strobe
    // a read and a write in one cycle return the value from before the write
    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata_r <= 16'h0000;
            reg_rvalid_r <= 1'b0;
        end else begin
            reg_rvalid_r <= reg_rd;
            if (reg_rd) begin
                reg_rdata_r <= rd_mux;
            end
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign reg_rvalid = reg_rvalid_r;

    // transmit space monitor
    logic monitor_en;
    logic space_met;
    logic space_done_r;
    logic space_pulse;
    logic space_pulse_r;

    // the free count is a level from the queue manager, compared every cycle
    assign monitor_en = tx_queue_control[qtf_pkg::TX_MEM_MONITOR_BIT];
    assign space_met = monitor_en && (tx_queue_free_dw >= tx_next_frame_space_r);
    // one event per request: without the done flag a large free queue would
    // keep setting the status bit every cycle after the host cleared it
    assign space_pulse = space_met && !space_done_r;

    // a new request or a disabled monitor re-arms the event
    always_ff @(posedge clk) begin
        if (!resetn) begin
            space_done_r <= 1'b0;
            space_pulse_r <= 1'b0;
        end else begin
            space_pulse_r <= space_pulse;
            if (wr_next_space || !monitor_en) begin
                space_done_r <= 1'b0;
            end else if (space_pulse) begin
                space_done_r <= 1'b1;
            end
        end
    end

    // drives status bit 6 of the interrupt status register
    // registered so the status bit sees one clean single-cycle pulse
    assign tx_space_irq_set = space_pulse_r;

    // multicast hash filter
    logic [2:0] da_count_r;
    logic [2:0] da_count_nxt;
    logic is_mcast_r;
    logic last_byte;
    logic lookup_go_r;
    logic [31:0] da_crc;
    logic [5:0] hash_index;
    logic hash_mode;
    logic pass_all_mcast;
    logic [63:0] table_bits;
    logic lookup_done;
    logic lookup_accept;
    logic [5:0] hash_index_r;

    // count address bytes; only the sixth one triggers a lookup
    // frames shorter than six bytes are never judged; the next first mark restarts
    assign da_count_nxt = rx_da_first ? 3'h1 : da_count_r + 3'h1;
    assign last_byte = rx_da_valid && (da_count_nxt == 3'(qtf_pkg::DA_BYTES));

    always_ff @(posedge clk) begin
        if (!resetn) begin
            da_count_r <= 3'h0;
            is_mcast_r <= 1'b0;
            lookup_go_r <= 1'b0;
        end else begin
            lookup_go_r <= last_byte;
            if (rx_da_valid) begin
                // stop counting after six so trailing strobes start no lookup
                if (rx_da_first || da_count_r < 3'(qtf_pkg::DA_BYTES)) begin
                    da_count_r <= da_count_nxt;
                end
                if (rx_da_first) begin
                    is_mcast_r <= rx_da_byte[0]; // group bit of the address
                end
            end
        end
    end

    qtf_da_crc u_da_crc (
        .clk(clk),
        .resetn(resetn),
        .byte_valid(rx_da_valid),
        .byte_first(rx_da_first),
        .byte_data(rx_da_byte),
        .crc(da_crc)
    );

    // the crc keeps running on bytes past the sixth; only its value at go is used
    assign hash_index = da_crc[31:26];
    assign hash_mode = (rx_filter_mode == qtf_pkg::FILTER_MODE_HASH_PERFECT);
    assign pass_all_mcast = rx_control_one[qtf_pkg::RX_RECEIVE_ALL_BIT]
                            && rx_control_one[qtf_pkg::RX_MCAST_FILTER_BIT];
    assign table_bits = {multicast_hash_word_r[3], multicast_hash_word_r[2],
                         multicast_hash_word_r[1], multicast_hash_word_r[0]};

    qtf_hash_lookup u_hash_lookup (
        .clk(clk),
        .resetn(resetn),
        .go(lookup_go_r),
        .is_mcast(is_mcast_r),
        .table_bits(table_bits),
        .index(hash_index),
        .hash_mode(hash_mode),
        .pass_all_mcast(pass_all_mcast),
        .done(lookup_done),
        .accept(lookup_accept)
    );

    // index kept beside the decision for the receive path to log
    always_ff @(posedge clk) begin
        if (!resetn) begin
            hash_index_r <= 6'h00;
        end else if (lookup_go_r) begin
            hash_index_r <= hash_index;
        end
    end

    assign rx_filter_done = lookup_done;
    assign rx_filter_accept = lookup_accept;
    assign rx_hash_index = hash_index_r;

    // receive flow control with hysteresis
    logic flow_r;
    logic flow_nxt;

    // the gap between the marks keeps pause frames from chattering
    // with the marks crossed over the set term wins, so the queue fails safe
    assign flow_nxt = (rx_queue_free_dw < rx_flow_high_mark_r) ? 1'b1 :
                      (rx_queue_free_dw > rx_flow_low_mark_r) ? 1'b0 : flow_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            flow_r <= 1'b0;
        end else begin
            flow_r <= flow_nxt;
        end
    end

    assign rx_flow_ctrl = flow_r;
endmodule : qtf_space_hash_filter
`default_nettype wire

// ---- verification/qtf_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// host processor side of the register port
module qtf_host_model (
    input wire logic clk,
    output logic [11:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic [1:0] reg_be,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    // idle bus at time zero
    initial begin
        reg_addr = 12'h000;
        reg_wdata = 16'h0000;
        reg_be = 2'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one write; bus inverted after so a stale value is never mistaken for a fresh one
    task automatic wr(input logic [11:0] a, input logic [15:0] d,
                      input logic [1:0] be = 2'h3);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_be <= be;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    // one read; unknown result if no answer comes within four cycles
    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        d = 16'hXXXX;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            if (reg_rvalid === 1'b1) begin
                d = reg_rdata;
                break;
            end
        end
    endtask : rd
endmodule : qtf_host_model
`default_nettype wire

// ---- verification/qtf_props.sv ----
`timescale 1ns/100ps
`default_nettype none
// port relations of the read port, space event, hash decision
module qtf_props (
    input wire logic clk,
    input wire logic resetn,
    input wire logic reg_rd,
    input wire logic reg_rvalid,
    input wire logic [15:0] tx_queue_control,
    input wire logic [15:0] rx_control_one,
    input wire logic [2:0] rx_filter_mode,
    input wire logic tx_space_irq_set,
    input wire logic rx_da_valid,
    input wire logic rx_filter_done,
    input wire logic rx_filter_accept
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // read answer lands exactly one cycle after the strobe
    sequence rd_answer_s;
        ##1 reg_rvalid;
    endsequence
    // a decision is a single cycle wide
    sequence done_pulse_s;
        rx_filter_done ##1 !rx_filter_done;
    endsequence
    read_answer_a: assert property (reg_rd |-> rd_answer_s)
        else $error("read strobe not answered");
    read_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read data valid without strobe");
    space_single_a: assert property (tx_space_irq_set |=> !tx_space_irq_set)
        else $error("space event longer than one cycle");
    space_cause_a: assert property (tx_space_irq_set |-> $past(tx_queue_control[1]))
        else $error("space event with monitor off");
    done_timing_a: assert property (rx_filter_done |-> $past(rx_da_valid, 2))
        else $error("decision not two cycles after last byte");
    done_pulse_a: assert property (rx_filter_done |-> done_pulse_s)
        else $error("decision strobe too long");
    mode_bypass_a: assert property (rx_filter_done && $past(rx_filter_mode) != 3'h5
        |-> rx_filter_accept) else $error("frame dropped outside hash mode");
    all_mcast_a: assert property (rx_filter_done && $past(rx_control_one[4])
        && $past(rx_control_one[8]) |-> rx_filter_accept)
        else $error("frame dropped with receive all");
endmodule : qtf_props
bind qtf_space_hash_filter qtf_props u_props (.clk, .resetn, .reg_rd, .reg_rvalid,
    .tx_queue_control, .rx_control_one, .rx_filter_mode, .tx_space_irq_set, .rx_da_valid,
    .rx_filter_done, .rx_filter_accept);
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [11:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd_val;
    logic [1:0] reg_be;
    logic reg_wr, reg_rd, reg_rvalid, tx_space_irq_set, rx_filter_done, rx_filter_accept;
    logic rx_flow_ctrl;
    logic [5:0] rx_hash_index, ix;
    logic [15:0] tx_queue_control = 16'h0000;
    logic [15:0] rx_control_one = 16'h0000;
    logic [2:0] rx_filter_mode = 3'h5;
    logic [15:0] tx_queue_free_dw = 16'h0010;
    logic [7:0] rx_da_byte = 8'h00;
    logic rx_da_valid = 1'b0;
    logic rx_da_first = 1'b0;
    logic [11:0] rx_queue_free_dw = 12'hFFF;
    logic [11:0] ofs [9] = '{12'h19E, 12'h1A0, 12'h1A2, 12'h1A4, 12'h1A6, 12'h1B0,
        12'h1B2, 12'h1A8, 12'h1B1};
    logic [15:0] rst [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0600, 16'h0400, 16'h0000, 16'h0000};
    logic [47:0] mc = 48'h01005E0000FB;
    int failures = 0;
    int checked = 0;
    int irqs = 0;

    always #50 clk = ~clk;
    // counted on the falling edge so reads at the rising edge never race it
    always @(negedge clk) if (tx_space_irq_set === 1'b1) irqs++;

    qtf_space_hash_filter dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_be, .reg_wr,
        .reg_rd, .reg_rdata, .reg_rvalid, .tx_queue_control, .rx_control_one,
        .rx_filter_mode, .tx_queue_free_dw, .tx_space_irq_set, .rx_da_byte, .rx_da_valid,
        .rx_da_first, .rx_filter_done, .rx_filter_accept, .rx_hash_index, .rx_queue_free_dw,
        .rx_flow_ctrl);
    qtf_host_model u_host (.clk, .reg_addr, .reg_wdata, .reg_be, .reg_wr, .reg_rd,
        .reg_rdata, .reg_rvalid);

    task check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task results;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results

    // own crc: preset ones, bytes in order, bit 0 first, top six bits kept
    function automatic logic [5:0] da_hash(input logic [47:0] da);
        logic [31:0] c;
        logic fb;
        c = qtf_pkg::CRC_INIT;
        for (int k = 0; k < 48; k++) begin
            fb = c[31] ^ da[40 - 8 * (k / 8) + (k % 8)];
            c = {c[30:0], 1'b0} ^ (fb ? qtf_pkg::CRC_POLY : 32'h00000000);
        end
        return c[31:26];
    endfunction : da_hash

    // six address bytes, then the decision and its index are compared
    task frame(input logic [47:0] da, input logic exp);
        for (int j = 0; j < 6; j++) begin
            @(posedge clk);
            rx_da_valid <= 1'b1;
            rx_da_first <= (j == 0);
            rx_da_byte <= da[47 - 8 * j -: 8];
        end
        @(posedge clk);
        rx_da_valid <= 1'b0;
        rx_da_first <= 1'b0;
        rx_da_byte <= ~rx_da_byte;
        for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            if (rx_filter_done === 1'b1) break;
        end
        check({14'h0, rx_filter_done, rx_filter_accept}, {14'h0, 1'b1, exp});
        check({10'h0, rx_hash_index}, {10'h0, da_hash(da)});
    endtask : frame

    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            u_host.rd(ofs[i], rd_val);
            check(rd_val, rst[i]);
        end
        u_host.wr(12'h1B0, 16'hFFFF);
        u_host.rd(12'h1B0, rd_val);
        check(rd_val, 16'h0FFF);
        u_host.wr(12'h1B0, 16'h0600);
        u_host.wr(12'h1A6, 16'hA5C3);
        u_host.wr(12'h1A8, 16'hFFFF);
        u_host.rd(12'h1A6, rd_val);
        check(rd_val, 16'hA5C3);
        u_host.wr(12'h1A6, 16'h0F0F, 2'h1);
        u_host.rd(12'h1A6, rd_val);
        check(rd_val, 16'hA50F);
        u_host.wr(12'h1B2, 16'hF3FF);
        u_host.rd(12'h1B2, rd_val);
        check(rd_val, 16'h03FF);
        u_host.wr(12'h1B2, 16'h0400);
        u_host.wr(12'h1A6, 16'h0000);
        // space request above what is free, then met, then re-armed
        u_host.wr(12'h19E, 16'h0020);
        tx_queue_control <= 16'h0002;
        repeat (4) @(posedge clk);
        check(irqs[15:0], 16'h0000);
        tx_queue_free_dw <= 16'h0020;
        repeat (4) @(posedge clk);
        check(irqs[15:0], 16'h0001);
        u_host.wr(12'h19E, 16'h0020);
        repeat (4) @(posedge clk);
        check(irqs[15:0], 16'h0002);
        // monitor off refuses the met request, turning it back on re-arms
        tx_queue_control <= 16'h0000;
        repeat (4) @(posedge clk);
        check(irqs[15:0], 16'h0002);
        tx_queue_control <= 16'h0002;
        repeat (4) @(posedge clk);
        check(irqs[15:0], 16'h0003);
        // hash bit set, cleared, then the receive-all bits
        ix = da_hash(mc);
        u_host.wr(12'h1A0 + {9'h0, ix[5:4], 1'b0}, 16'h0001 << ix[3:0]);
        frame(mc, 1'b1);
        u_host.wr(12'h1A0 + {9'h0, ix[5:4], 1'b0}, 16'h0000);
        frame(mc, 1'b0);
        rx_control_one <= 16'h0010;
        frame(mc, 1'b0);
        rx_control_one <= 16'h0110;
        frame(mc, 1'b1);
        rx_control_one <= 16'h0000;
        for (int m = 0; m < 8; m++) begin
            rx_filter_mode <= m[2:0];
            frame(mc, m != 5);
        end
        rx_filter_mode <= 3'h5;
        frame(48'h02005E0000FB, 1'b1);
        // below high mark, between marks, above low mark
        for (int f = 0; f < 3; f++) begin
            rx_queue_free_dw <= (f == 0) ? 12'h3FF : (f == 1) ? 12'h500 : 12'h601;
            repeat (3) @(posedge clk);
            check({15'h0, rx_flow_ctrl}, {15'h0, f != 2});
        end
        results();
    end

    // watchdog well beyond the expected run of a few hundred cycles
    initial begin
        #1000000;
        failures++;
        results();
    end
endmodule : testbench
`default_nettype wire
